// ===== core/adc_board_pkg.sv
// Shared constants for the analog input board control logic.
package adc_board_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SETTLE_TIME_NS = 15000;
    localparam int CONV_TIME_NS = 25000;
    // Least times round up to whole cycles.
    localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYCLES_DEF = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Address decode
    localparam logic [2:0] ADDR_PAGE = 3'h7;
    localparam logic [1:0] CTRL_INDEX = 2'h0;
    localparam logic [1:0] RESULT_INDEX = 2'h1;
    localparam logic [2:0] VECTOR_ERR_OFS = 3'h4;
    localparam logic [2:0] VECTOR_DONE_OFS = 3'h0;

    // ==========================================================
    // Control/status field positions
    localparam int START_BIT = 0;
    localparam int GAIN_SEL_LOW_BIT = 2;
    localparam int GAIN_SEL_HIGH_BIT = 3;
    localparam int EXT_TRIGGER_EN_BIT = 4;
    localparam int RTC_EN_BIT = 5;
    localparam int DONE_IE_BIT = 6;
    localparam int DONE_BIT = 7;
    localparam int CHAN_LSB = 8;
    localparam int CHAN_MSB = 11;
    localparam int ERR_IE_BIT = 14;
    localparam int ERR_BIT = 15;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // ==========================================================
    // Output notation selection
    localparam logic [1:0] NOTE_BINARY = 2'h0;
    localparam logic [1:0] NOTE_OFFSET = 2'h1;
    localparam logic [1:0] NOTE_TWOS = 2'h2;

endpackage

// ===== core/pin_sync.sv
// Two-stage pin synchroniser with a registered falling-edge pulse per bit.
`timescale 1ns/100ps
module pin_sync
#(
    parameter int        WIDTH = 4,
    parameter bit        IDLE  = 1'b1
)
(
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] levelOut,
    output logic      [WIDTH-1:0] fallPulse
);

    if (WIDTH < 1)
    begin : badWidth
        $error("pin_sync needs at least one bit");
    end

    // ==========================================================
    // Per-bit synchroniser
    for (genvar i = 0; i < WIDTH; i++)
    begin : bitSync
        logic meta_r;
        logic stable_r;
        logic prev_r;

        // The first stage feeds only the second stage.
        always_ff @(posedge sys_clk)
        begin
            if (reset)
            begin
                meta_r <= IDLE;
                stable_r <= IDLE;
                prev_r <= IDLE;
                fallPulse[i] <= 1'b0;
            end
            else
            begin
                meta_r <= pinIn[i];
                stable_r <= meta_r;
                prev_r <= stable_r;
                fallPulse[i] <= prev_r & ~stable_r;
            end
        end

        assign levelOut[i] = stable_r;
    end

endmodule

// ===== core/adc_board_ctrl.sv
// Control and status logic of a 16-channel analog input board on a parallel bus.
`timescale 1ns/100ps

// How it works
// - Bits 3:2 choose gain 1, 2, 4, 8.
// - Bits 4, 5 enable trigger and clock starts.
// - Interrupt on done or error when enabled.
// - Bit 14 lets error bit 15 interrupt.
// - Bus initialize clears error and its enable.
// - Hardware start while settling sets error.
// - Start while converting sets error.
// - Start while done still set sets error.
// - Control write or initialize clears error.
// - Bits 11:8 pick channel; differential uses 0-7.
// - Result holds until next conversion ends.
// - Two's complement fills bits 15:12 with sign.
// - Output notation chosen by configuration input.
// - Address bits 12:3 compared with jumpers.
// - Vector base for done, base+4 error.
// - Base vector from jumper bits 8:3.
// - Three start sources: software, clock, trigger.
// - Trigger from bus event or connector.
// - Writing one to bit 0 starts.
// - Completion sets done, sampler tracks again.
// - Result read or initialize clears done.
module adc_board_ctrl
    import adc_board_pkg::*;
#(
    parameter int        CONV_CYCLES = adc_board_pkg::CONV_CYCLES_DEF
)
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        busInit,
    input  wire logic [15:0] busAddr,
    input  wire logic        busWrite,
    input  wire logic        busRead,
    input  wire logic [1:0]  byteEn,
    input  wire logic [15:0] busWrData,
    input  wire logic        iack,
    input  wire logic [9:0]  addrJumpers,
    input  wire logic [5:0]  vecJumpers,
    input  wire logic [1:0]  notationSel,
    input  wire logic        input_topology_select,
    input  wire logic        trigSourceSel,
    input  wire logic        bus_event_line_n,
    input  wire logic        trigger_input_n,
    input  wire logic        rtcInputN,
    input  wire logic [11:0] convData,
    output logic      [15:0] rdData,
    output logic             busAck,
    output logic             irqReq,
    output logic      [8:0]  vectorOut,
    output logic             vectorValid,
    output logic             holdSample,
    output logic      [3:0]  channelSel,
    output logic      [1:0]  gainSel
);
    import adc_board_pkg::*;

    localparam int CNT_W = $clog2(CONV_CYCLES + 1);
    localparam int SET_W = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CONV_LOAD = CNT_W'(CONV_CYCLES);
    localparam logic [SET_W-1:0] SETTLE_LOAD = SET_W'(SETTLE_CYCLES);

    if (CONV_CYCLES < 2 || CONV_CYCLES > 65535)
    begin : badConv
        $error("CONV_CYCLES must lie between 2 and 65535");
    end

    // ==========================================================
    // Synchronised pins
    logic [22:0] pinLevel;
    logic [22:0] pinFall;
    logic [9:0]  addrSel;
    logic [5:0]  vecSel;
    logic [1:0]  noteSel;
    logic        diffMode;
    logic        connSel;
    logic        busEvent;
    logic        connTrig;
    logic        rtcEvent;

    pin_sync #(.WIDTH(23), .IDLE(1'b1)) pinSync
    (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .pinIn     ({addrJumpers, vecJumpers, notationSel, input_topology_select,
                     trigSourceSel, bus_event_line_n, trigger_input_n, rtcInputN}),
        .levelOut  (pinLevel),
        .fallPulse (pinFall)
    );

    assign addrSel = pinLevel[22:13];
    assign vecSel = pinLevel[12:7];
    assign noteSel = pinLevel[6:5];
    assign diffMode = pinLevel[4];
    assign connSel = pinLevel[3];
    assign busEvent = pinFall[2];
    assign connTrig = pinFall[1];
    assign rtcEvent = pinFall[0];

    // ==========================================================
    // Register state
    logic [1:0]       gain_r;
    logic             extEn_r;
    logic             rtcEn_r;
    logic             doneIe_r;
    logic             done_r;
    logic [3:0]       chan_r;
    logic             errIe_r;
    logic             err_r;
    logic [15:0]      result_r;
    logic [CNT_W-1:0] convCnt_r;
    logic [SET_W-1:0] settleCnt_r;

    // Two's complement flips the offset code's top bit and spreads the sign upward.
    function automatic logic [15:0] formatResult(input logic [11:0] raw, input logic [1:0] note);
        logic [11:0] twos;
        twos = {~raw[11], raw[10:0]};
        if (note == NOTE_TWOS)
            formatResult = {{4{twos[11]}}, twos};
        else
            formatResult = {4'h0, raw};
    endfunction

    // ==========================================================
    // Bus decode
    logic pageHit;
    logic ctrlHit;
    logic resHit;
    logic wrCtrl;
    logic wrLo;
    logic wrHi;
    logic rdRes;
    logic [15:0] ctrlView;
    logic [15:0] readMux;

    assign pageHit = (busAddr[15:13] == ADDR_PAGE) && (busAddr[12:3] == addrSel);
    assign ctrlHit = pageHit && (busAddr[2:1] == CTRL_INDEX);
    assign resHit = pageHit && (busAddr[2:1] == RESULT_INDEX);
    assign wrCtrl = busWrite & ctrlHit;
    assign wrLo = wrCtrl & byteEn[0];
    assign wrHi = wrCtrl & byteEn[1];
    assign rdRes = busRead & resHit;
    assign ctrlView = {err_r, errIe_r, 2'b00, chan_r, done_r, doneIe_r, rtcEn_r, extEn_r, gain_r, 2'b00};
    assign readMux = ctrlHit ? ctrlView : result_r;

    // ==========================================================
    // Start sources and refusal
    logic swStart;
    logic extStart;
    logic rtcStart;
    logic hwStart;
    logic startReq;
    logic busy;
    logic settling;
    logic errEvent;
    logic startOk;
    logic finish;
    logic chanChange;

    assign swStart = wrLo & busWrData[START_BIT];
    assign extStart = extEn_r & (connSel ? connTrig : busEvent);
    assign rtcStart = rtcEn_r & rtcEvent;
    assign hwStart = extStart | rtcStart;
    assign startReq = swStart | hwStart;
    assign busy = convCnt_r != '0;
    assign settling = settleCnt_r != '0;
    assign errEvent = (startReq & (busy | done_r)) | (hwStart & settling);
    assign startOk = startReq & ~errEvent;
    assign finish = convCnt_r == CNT_W'(1);
    assign chanChange = wrHi && (busWrData[CHAN_MSB:CHAN_LSB] != chan_r);

    // ==========================================================
    // Control fields; each byte lane writes its own half.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            {gain_r, extEn_r, rtcEn_r, doneIe_r} <= CTRL_RESET[DONE_IE_BIT:GAIN_SEL_LOW_BIT];
            chan_r <= CTRL_RESET[CHAN_MSB:CHAN_LSB];
            errIe_r <= CTRL_RESET[ERR_IE_BIT];
        end
        else
        begin
            if (wrLo)
            begin
                gain_r <= busWrData[GAIN_SEL_HIGH_BIT:GAIN_SEL_LOW_BIT];
                extEn_r <= busWrData[EXT_TRIGGER_EN_BIT];
                rtcEn_r <= busWrData[RTC_EN_BIT];
                doneIe_r <= busWrData[DONE_IE_BIT];
            end
            if (wrHi)
            begin
                chan_r <= busWrData[CHAN_MSB:CHAN_LSB];
                errIe_r <= busWrData[ERR_IE_BIT];
            end
            if (busInit)
            begin
                doneIe_r <= 1'b0;
                errIe_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Flags: a hardware set wins over a same-cycle read or write clear; initialize wins over both.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            done_r <= CTRL_RESET[DONE_BIT];
            err_r <= CTRL_RESET[ERR_BIT];
        end
        else
        begin
            done_r <= busInit ? 1'b0 : (finish | (done_r & ~rdRes));
            err_r <= busInit ? 1'b0 : (errEvent | (err_r & ~wrCtrl));
        end
    end

    // ==========================================================
    // Conversion latency and multiplexer settling counters.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            convCnt_r <= '0;
            settleCnt_r <= '0;
            result_r <= RESULT_RESET;
        end
        else
        begin
            if (startOk)
                convCnt_r <= CONV_LOAD;
            else if (busy)
                convCnt_r <= convCnt_r - CNT_W'(1);
            if (chanChange)
                settleCnt_r <= SETTLE_LOAD;
            else if (settling)
                settleCnt_r <= settleCnt_r - SET_W'(1);
            if (finish)
                result_r <= formatResult(convData, noteSel);
        end
    end

    // ==========================================================
    // Registered outputs; the bus answers one cycle after a hit.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            rdData <= 16'h0000;
            busAck <= 1'b0;
            irqReq <= 1'b0;
            vectorOut <= 9'h000;
            vectorValid <= 1'b0;
            holdSample <= 1'b0;
            channelSel <= 4'h0;
            gainSel <= 2'h0;
        end
        else
        begin
            // Unmapped indices on the page return zero, as they are not answered.
            rdData <= (busRead & (ctrlHit | resHit)) ? readMux : 16'h0000;
            busAck <= (busRead | busWrite) & (ctrlHit | resHit);
            irqReq <= (done_r & doneIe_r) | (err_r & errIe_r);
            vectorValid <= iack & irqReq;
            if (iack & irqReq)
                vectorOut <= {vecSel, (done_r & doneIe_r) ? VECTOR_DONE_OFS : VECTOR_ERR_OFS};
            holdSample <= startOk | (busy & ~finish);
            channelSel <= diffMode ? {1'b0, chan_r[2:0]} : chan_r;
            gainSel <= gain_r;
        end
    end

    // ==========================================================
    // Checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    chk_irq_cause: assert property (
        irqReq == $past((done_r & doneIe_r) | (err_r & errIe_r)))
        else $error("interrupt request does not follow its flags");
    chk_err_gate: assert property (
        (err_r && !errIe_r && !(done_r && doneIe_r)) |=> !irqReq)
        else $error("error interrupt raised while disabled");
    chk_init_clear: assert property (
        busInit |=> !err_r && !errIe_r && !done_r && !doneIe_r)
        else $error("initialize left a flag or enable set");
    chk_settle_err: assert property (
        (hwStart && settling && !busInit) |=> err_r)
        else $error("start during settling did not flag error");
    chk_busy_err: assert property (
        (startReq && busy && !busInit) |=> err_r && (convCnt_r == $past(convCnt_r) - CNT_W'(1)))
        else $error("start while converting did not flag error");
    chk_done_err: assert property (
        (startReq && done_r && !busInit) |=> err_r)
        else $error("start with done set did not flag error");
    chk_write_clear: assert property (
        (wrCtrl && !errEvent && err_r) |=> !err_r)
        else $error("control write did not clear error");
    chk_disabled_src: assert property (
        (!extEn_r && !rtcEn_r && !swStart && !busy) |=> !busy)
        else $error("disabled source started a conversion");
    chk_conv_start: assert property (
        startOk |=> busy && holdSample ##1 holdSample)
        else $error("accepted start did not enter conversion");
    chk_sign_fill: assert property (
        $past(finish) |-> result_r[15:12] == (($past(noteSel) == NOTE_TWOS) ? {4{result_r[11]}} : 4'h0))
        else $error("result upper bits do not follow notation");
    chk_vector: assert property (
        (iack && irqReq && !(done_r && doneIe_r)) |=> vectorValid && vectorOut[2:0] == VECTOR_ERR_OFS)
        else $error("error vector not base plus four");
    chk_read_zero: assert property (
        $past(busRead && ctrlHit) |-> rdData[1:0] == 2'b00 && rdData[13:12] == 2'b00)
        else $error("unused control bits read non-zero");

endmodule

// ===== bench/adc_far_side_model.sv
// Far side model: trigger pins, clock start pin and converter data source.
`timescale 1ns/100ps
module adc_far_side_model
(
    input  wire logic        sys_clk,
    input  wire logic        holdSample,
    input  wire logic [11:0] rawCode,
    output logic             bus_event_line_n,
    output logic             trigger_input_n,
    output logic             rtcInputN,
    output logic      [11:0] convData
);
    // ==========================================================
    // Start pins
    // The pulled-up pins idle high between events.
    initial
    begin
        bus_event_line_n = 1'b1;
        trigger_input_n = 1'b1;
        rtcInputN = 1'b1;
    end

    // One event pulls a pin low for four cycles: 0 bus event, 1 connector, 2 clock.
    // active low trigger
    task automatic fire(input int src);
        @(negedge sys_clk);
        case (src)
            0: bus_event_line_n = 1'b0;
            1: trigger_input_n = 1'b0;
            default: rtcInputN = 1'b0;
        endcase
        repeat (4) @(negedge sys_clk);
        bus_event_line_n = 1'b1;
        trigger_input_n = 1'b1;
        rtcInputN = 1'b1;
    endtask

    // ==========================================================
    // Converter data
    // Outside hold the code is not valid, so it shows the inverse to catch an early sample.
    // code held while converting
    assign convData = holdSample ? rawCode : ~rawCode;
endmodule

// ===== bench/adc_board_bus_control_test.sv
// Self-checking testbench of the analog input board control logic.
`timescale 1ns/100ps
module adc_board_bus_control_test;
    import adc_board_pkg::*;

    // ==========================================================
    // Signals
    logic        sys_clk, reset, busInit, busWrite, busRead, iack;
    logic        input_topology_select, trigSourceSel, rtcInputN;
    logic        bus_event_line_n, trigger_input_n;
    logic        busAck, irqReq, vectorValid, holdSample;
    logic [15:0] busAddr, busWrData, rdData;
    logic [1:0]  byteEn, notationSel, gainSel;
    logic [9:0]  addrJumpers;
    logic [5:0]  vecJumpers;
    logic [11:0] convData, rawCode;
    logic [8:0]  vectorOut;
    logic [3:0]  channelSel;
    int          err_total, checked;
    int          cycles = 0;

    adc_board_ctrl #(.CONV_CYCLES(8)) i_dut (.sys_clk(sys_clk), .reset(reset), .busInit(busInit),
        .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead), .byteEn(byteEn), .busWrData(busWrData),
        .iack(iack), .addrJumpers(addrJumpers), .vecJumpers(vecJumpers), .notationSel(notationSel),
        .input_topology_select(input_topology_select), .trigSourceSel(trigSourceSel),
        .bus_event_line_n(bus_event_line_n), .trigger_input_n(trigger_input_n), .rtcInputN(rtcInputN),
        .convData(convData), .rdData(rdData), .busAck(busAck), .irqReq(irqReq), .vectorOut(vectorOut),
        .vectorValid(vectorValid), .holdSample(holdSample), .channelSel(channelSel), .gainSel(gainSel));

    adc_far_side_model i_far (.sys_clk(sys_clk), .holdSample(holdSample), .rawCode(rawCode),
        .bus_event_line_n(bus_event_line_n), .trigger_input_n(trigger_input_n), .rtcInputN(rtcInputN),
        .convData(convData));

    // ==========================================================
    // Clock and hang guard
    // The guard sits far above the roughly 2200 cycles the sequence needs.
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total = err_total + 1;
            stop_test();
        end
    end

    // ==========================================================
    // Shared tasks
    // Counts every compare and reports a mismatch at once.
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
            err_total = err_total + 1;
        end
    endtask

    // One bus access; the strobe is raised a full cycle after any earlier drop.
    task automatic acc(input logic wr, input logic [1:0] idx, input logic [15:0] d, input logic [1:0] be,
                       input logic [15:0] exp);
        @(negedge sys_clk);
        busAddr = {3'b111, addrJumpers, idx, 1'b0};
        busWrData = d;
        byteEn = be;
        busWrite = wr;
        busRead = ~wr;
        @(negedge sys_clk);
        busWrite = 1'b0;
        busRead = 1'b0;
        check("busAck", busAck, (idx == 2'h2) ? 1'b0 : 1'b1);
        if (!wr)
            check("rdData", rdData, exp);
    endtask

    task automatic ackIrq(input logic [8:0] exp);
        @(negedge sys_clk);
        iack = 1'b1;
        @(negedge sys_clk);
        iack = 1'b0;
        check("vectorValid", vectorValid, 1'b1);
        check("vectorOut", vectorOut, exp);
    endtask

    // Waits a bounded time for the conversion to finish.
    task automatic waitIdle();
        int n;
        n = 0;
        while (holdSample !== 1'b0 && n < 20)
        begin
            @(negedge sys_clk);
            n = n + 1;
        end
        check("holdSampleEnd", holdSample, 1'b0);
    endtask

    task automatic hwTry(input int src, input logic expStart);
        logic seen;
        seen = 1'b0;
        i_far.fire(src);
        repeat (8)
        begin
            @(negedge sys_clk);
            seen = seen | holdSample;
        end
        check("started", seen, expStart);
        if (expStart)
        begin
            waitIdle();
            acc(1'b0, 2'h1, 16'h0, 2'h0, {4'h0, rawCode});
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        acc(1'b0, 2'h0, 16'h0, 2'h0, 16'h0000);
        acc(1'b0, 2'h1, 16'h0, 2'h0, 16'h0000);
        acc(1'b0, 2'h2, 16'h0, 2'h0, 16'h0000);
    endtask

    // Software starts under each notation, with the extreme codes.
    task automatic t_convert();
        logic [1:0]  nt[4] = '{NOTE_BINARY, NOTE_OFFSET, NOTE_TWOS, NOTE_TWOS};
        logic [11:0] rc[4] = '{12'hfff, 12'h800, 12'hfff, 12'h000};
        logic [15:0] ex[4] = '{16'h0fff, 16'h0800, 16'h07ff, 16'hf800};
        for (int i = 0; i < 4; i++)
        begin
            notationSel = nt[i];
            rawCode = rc[i];
            repeat (4) @(negedge sys_clk);
            acc(1'b1, 2'h0, 16'h0549, 2'h3, 16'h0);
            check("holdSample", holdSample, 1'b1);
            waitIdle();
            // The pin copies trail the register by one cycle, so they are looked at later.
            check("gainSel", gainSel, 2'h2);
            check("channelSel", channelSel, 4'h5);
            repeat (2) @(negedge sys_clk);
            check("irqReq", irqReq, 1'b1);
            ackIrq(9'h100);
            acc(1'b0, 2'h0, 16'h0, 2'h0, 16'h05c8);
            acc(1'b0, 2'h1, 16'h0, 2'h0, ex[i]);
            acc(1'b0, 2'h1, 16'h0, 2'h0, ex[i]);
            acc(1'b0, 2'h0, 16'h0, 2'h0, 16'h0548);
        end
    endtask

    task automatic t_errors();
        acc(1'b1, 2'h0, 16'h4001, 2'h3, 16'h0);
        acc(1'b1, 2'h0, 16'h4001, 2'h3, 16'h0);
        @(negedge sys_clk);
        check("irqReqErr", irqReq, 1'b1);
        ackIrq(9'h104);
        waitIdle();
        acc(1'b0, 2'h0, 16'h0, 2'h0, 16'hc080);
        acc(1'b1, 2'h0, 16'h4000, 2'h3, 16'h0);
        acc(1'b0, 2'h0, 16'h0, 2'h0, 16'h4080);
        acc(1'b1, 2'h0, 16'h4001, 2'h3, 16'h0);
        check("holdSample", holdSample, 1'b0);
        acc(1'b0, 2'h0, 16'h0, 2'h0, 16'hc080);
        @(negedge sys_clk);
        busInit = 1'b1;
        @(negedge sys_clk);
        busInit = 1'b0;
        acc(1'b0, 2'h0, 16'h0, 2'h0, 16'h0000);
    endtask

    // Hardware starts: enables, trigger source choice and settling after a channel change.
    task automatic t_hw();
        notationSel = NOTE_BINARY;
        rawCode = 12'h5a3;
        trigSourceSel = 1'b1;
        acc(1'b1, 2'h0, 16'h0a00, 2'h3, 16'h0);
        hwTry(1, 1'b0);
        acc(1'b1, 2'h0, 16'h0010, 2'h1, 16'h0);
        hwTry(1, 1'b0);
        acc(1'b0, 2'h0, 16'h0, 2'h0, 16'h8a10);
        repeat (1900) @(negedge sys_clk);
        acc(1'b1, 2'h0, 16'h0010, 2'h1, 16'h0);
        hwTry(1, 1'b1);
        trigSourceSel = 1'b0;
        repeat (4) @(negedge sys_clk);
        hwTry(0, 1'b1);
        hwTry(1, 1'b0);
        acc(1'b1, 2'h0, 16'h0020, 2'h1, 16'h0);
        hwTry(2, 1'b1);
        hwTry(0, 1'b0);
        input_topology_select = 1'b1;
        repeat (4) @(negedge sys_clk);
        acc(1'b1, 2'h0, 16'h0d00, 2'h2, 16'h0);
        @(negedge sys_clk);
        check("channelDiff", channelSel, 4'h5);
    endtask

    // ==========================================================
    // Closing report
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Reset is held three cycles; the jumpers pass the synchronisers before the first access.
    initial
    begin
        err_total = 0;
        checked = 0;
        reset = 1'b1;
        busInit = 1'b0;
        busWrite = 1'b0;
        busRead = 1'b0;
        iack = 1'b0;
        busAddr = 16'h0000;
        busWrData = 16'h0000;
        byteEn = 2'h0;
        addrJumpers = 10'h220;
        vecJumpers = 6'h20;
        notationSel = NOTE_BINARY;
        input_topology_select = 1'b0;
        trigSourceSel = 1'b0;
        rawCode = 12'h000;
        repeat (3) @(negedge sys_clk);
        reset = 1'b0;
        repeat (4) @(negedge sys_clk);
        t_regs();
        t_convert();
        t_errors();
        t_hw();
        stop_test();
    end
endmodule
